//--- hw/ifsp_top.sv
// Notes on behaviour
// - link is four lines: data in, clock in, data out, clear-to-send out
// - both directions are clocked by link_clk_in, never driven here
// - clear_to_send_n low while a frame's start bit and data bits go out, high otherwise
// - suspended with wakeup enabled, a low wake strobe requests resume
// - powered, a low wake strobe gives a one-cycle flush_req pulse, the receive buffer is not touched
`timescale 1ns/1ps
`default_nettype none
module ifsp_top (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               link_clk_in,
    input  wire logic               ser_data_in,
    output logic                    ser_data_out,
    output logic                    clear_to_send_n,
    input  wire logic               wake_flush_n,
    input  wire logic               power_enable_n,
    input  wire logic               remote_wakeup_en,
    input  wire logic               tx_valid,
    output logic                    tx_ready,
    input  wire ifsp_pkg::ifsp_word_t tx_data,
    output logic                    rx_valid,
    input  wire logic               rx_ready,
    output ifsp_pkg::ifsp_word_t    rx_data,
    output logic                    flush_req,
    output logic                    resume_req
);
    import ifsp_pkg::*;

    // ************************************************************
    // core side: transmit holding word
    // ************************************************************
    ifsp_word_t            tx_hold_reg;
    logic                  tx_req_reg;
    logic                  tx_ready_reg;
    logic [SYNC_DEPTH-1:0] tx_ack_sync_reg;
    logic                  tx_ack_reg;
    logic                  tx_done_reg;
    logic                  tx_accept;

    assign tx_accept = tx_valid & tx_ready_reg;
    assign tx_ready  = tx_ready_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_hold_reg <= WORD_RST;
            tx_req_reg  <= 1'b0;
        end else if (tx_accept) begin
            tx_hold_reg <= tx_data;
            tx_req_reg  <= ~tx_req_reg;
        end
    end

    // ************************************************************
    // core side: transmit done sync
    // ************************************************************

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ack_sync_reg <= '0;
            tx_ack_reg      <= 1'b0;
        end else begin
            tx_ack_sync_reg <= {tx_ack_sync_reg[1:0], tx_done_reg};
            if (tx_ack_sync_reg[1] == tx_ack_sync_reg[2]) begin
                tx_ack_reg <= tx_ack_sync_reg[2];
            end
        end
    end

    // ************************************************************
    // core side: transmit ready
    // ************************************************************

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ready_reg <= 1'b0;
        end else begin
            tx_ready_reg <= !tx_accept && (tx_req_reg == tx_ack_reg);
        end
    end

    // ************************************************************
    // link side: transmit framer
    // ************************************************************
    logic [SYNC_DEPTH-1:0] lk_req_sync_reg;
    logic                  lk_seen_reg;
    logic                  tx_active_reg;
    ifsp_cnt_t             tx_cnt_reg;
    ifsp_word_t            tx_shift_reg;
    logic                  ser_out_reg;
    logic                  cts_n_reg;
    logic                  tx_pending;
    logic                  tx_load;

    assign tx_pending = (lk_req_sync_reg[1] == lk_req_sync_reg[2]) &&
                        (lk_req_sync_reg[2] != lk_seen_reg);
    assign tx_load    = tx_pending & ~tx_active_reg;

    // ************************************************************
    // link side: request sync
    // ************************************************************

    always_ff @(posedge link_clk_in or posedge rst) begin
        if (rst) begin
            lk_req_sync_reg <= '0;
        end else begin
            lk_req_sync_reg <= {lk_req_sync_reg[1:0], tx_req_reg};
        end
    end

    // ************************************************************
    // link side: frame shifter
    // ************************************************************

    always_ff @(posedge link_clk_in or posedge rst) begin
        if (rst) begin
            lk_seen_reg   <= 1'b0;
            tx_done_reg   <= 1'b0;
            tx_active_reg <= 1'b0;
            tx_cnt_reg    <= CNT_ZERO;
            tx_shift_reg  <= WORD_RST;
            ser_out_reg   <= LINE_IDLE;
        end else if (tx_load) begin
            lk_seen_reg   <= lk_req_sync_reg[2];
            tx_active_reg <= 1'b1;
            tx_cnt_reg    <= TX_BITS;
            tx_shift_reg  <= tx_hold_reg;
            ser_out_reg   <= START_BIT;
        end else if (tx_active_reg) begin
            tx_cnt_reg <= tx_cnt_reg - CNT_ONE;
            if (tx_cnt_reg == CNT_ONE) begin
                ser_out_reg   <= TRAIL_BIT;
                tx_active_reg <= 1'b0;
                tx_done_reg   <= ~tx_done_reg;
            end else begin
                ser_out_reg  <= tx_shift_reg[0];
                tx_shift_reg <= {1'b0, tx_shift_reg[WORD_W-1:1]};
            end
        end
    end

    // ************************************************************
    // link side: clear to send
    // ************************************************************

    always_ff @(posedge link_clk_in or posedge rst) begin
        if (rst) begin
            cts_n_reg <= CTS_N_RST;
        end else begin
            cts_n_reg <= !(tx_load ||
                           (tx_active_reg && tx_cnt_reg != CNT_ONE));
        end
    end

    assign ser_data_out    = ser_out_reg;
    assign clear_to_send_n = cts_n_reg;

    // ************************************************************
    // link side: receive deframer
    // ************************************************************
    logic                  rx_active_reg;
    ifsp_cnt_t             rx_cnt_reg;
    ifsp_word_t            rx_shift_reg;
    ifsp_word_t            rx_hold_reg;
    logic                  rx_tgl_reg;
    logic [SYNC_DEPTH-1:0] lk_ack_sync_reg;
    logic                  lk_ack_reg;
    logic                  rx_taken_reg;
    logic                  rx_hold_busy;

    assign rx_hold_busy = rx_tgl_reg != lk_ack_reg;

    // ************************************************************
    // link side: receive ack sync
    // ************************************************************

    always_ff @(posedge link_clk_in or posedge rst) begin
        if (rst) begin
            lk_ack_sync_reg <= '0;
            lk_ack_reg      <= 1'b0;
        end else begin
            lk_ack_sync_reg <= {lk_ack_sync_reg[1:0], rx_taken_reg};
            if (lk_ack_sync_reg[1] == lk_ack_sync_reg[2]) begin
                lk_ack_reg <= lk_ack_sync_reg[2];
            end
        end
    end

    // ************************************************************
    // link side: frame capture
    // ************************************************************

    always_ff @(posedge link_clk_in or posedge rst) begin
        if (rst) begin
            rx_active_reg <= 1'b0;
            rx_cnt_reg    <= CNT_ZERO;
            rx_shift_reg  <= WORD_RST;
            rx_hold_reg   <= WORD_RST;
            rx_tgl_reg    <= 1'b0;
        end else if (!rx_active_reg) begin
            if (ser_data_in == START_BIT) begin
                rx_active_reg <= 1'b1;
                rx_cnt_reg    <= DATA_BITS;
            end
        end else if (rx_cnt_reg != CNT_ZERO) begin
            rx_shift_reg <= {ser_data_in, rx_shift_reg[WORD_W-1:1]};
            rx_cnt_reg   <= rx_cnt_reg - CNT_ONE;
        end else begin
            rx_active_reg <= 1'b0;
            // bad trailing bit or full holding word: frame dropped
            if (ser_data_in == TRAIL_BIT && !rx_hold_busy) begin
                rx_hold_reg <= rx_shift_reg;
                rx_tgl_reg  <= ~rx_tgl_reg;
            end
        end
    end

    // ************************************************************
    // core side: receive word into the buffer
    // ************************************************************
    logic [SYNC_DEPTH-1:0] rx_sync_reg;
    logic                  rx_stable_reg;
    logic                  rx_new;

    ifsp_buf_if rx_bus ();

    ifsp_buf u_rx_buf (
        .clk (clk),
        .rst (rst),
        .bus (rx_bus)
    );

    assign rx_new           = rx_stable_reg != rx_taken_reg;
    assign rx_bus.in_valid  = rx_new;
    assign rx_bus.in_data   = rx_hold_reg;
    assign rx_bus.out_ready = rx_ready;
    assign rx_valid         = rx_bus.out_valid;
    assign rx_data          = rx_bus.out_data;

    // ************************************************************
    // core side: receive toggle sync
    // ************************************************************

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sync_reg   <= '0;
            rx_stable_reg <= 1'b0;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rx_tgl_reg};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_stable_reg <= rx_sync_reg[2];
            end
        end
    end

    // ************************************************************
    // core side: buffer push
    // ************************************************************

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_taken_reg <= 1'b0;
        end else if (rx_new && rx_bus.in_ready) begin
            rx_taken_reg <= rx_stable_reg;
        end
    end

    // ************************************************************
    // wake / flush strobe
    // ************************************************************
    logic [SYNC_DEPTH-1:0] wf_sync_reg;
    logic                  wf_level_reg;
    logic                  wf_fall;
    logic                  flush_req_reg;
    logic                  resume_req_reg;

    assign wf_fall = (wf_sync_reg[1] == wf_sync_reg[2]) &&
                     !wf_sync_reg[2] && wf_level_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wf_sync_reg  <= {SYNC_DEPTH{STRAP_RST}};
            wf_level_reg <= STRAP_RST;
        end else begin
            wf_sync_reg <= {wf_sync_reg[1:0], wake_flush_n};
            if (wf_sync_reg[1] == wf_sync_reg[2]) begin
                wf_level_reg <= wf_sync_reg[2];
            end
        end
    end

    // ************************************************************
    // core side: request pulses
    // ************************************************************

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flush_req_reg  <= 1'b0;
            resume_req_reg <= 1'b0;
        end else begin
            flush_req_reg  <= wf_fall && !power_enable_n;
            resume_req_reg <= wf_fall && power_enable_n &&
                              remote_wakeup_en;
        end
    end

    assign flush_req  = flush_req_reg;
    assign resume_req = resume_req_reg;

endmodule
`default_nettype wire

//--- hw/ifsp_pkg.sv
// ****************************************************************
// shared constants for the isolated fast serial port
// ****************************************************************
package ifsp_pkg;

    localparam int unsigned WORD_W     = 8;
    localparam int unsigned CNT_W      = 4;
    localparam int unsigned SYNC_DEPTH = 3;

    typedef logic [WORD_W-1:0] ifsp_word_t;
    typedef logic [CNT_W-1:0]  ifsp_cnt_t;

    // frame layout: start bit, data bits lsb first, trailing bit
    localparam logic       START_BIT   = 1'b0;
    localparam logic       TRAIL_BIT   = 1'b1;
    localparam ifsp_cnt_t  DATA_BITS   = 4'h8;
    localparam ifsp_cnt_t  TX_BITS     = 4'h9;
    localparam ifsp_cnt_t  CNT_ZERO    = 4'h0;
    localparam ifsp_cnt_t  CNT_ONE     = 4'h1;

    // values after reset
    localparam logic       LINE_IDLE   = 1'b1;
    localparam logic       CTS_N_RST   = 1'b1;
    localparam logic       STRAP_RST   = 1'b1;
    localparam ifsp_word_t WORD_RST    = 8'h00;

endpackage

//--- hw/ifsp_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// valid/ready word channel through the two-entry buffer
// ****************************************************************
interface ifsp_buf_if;
    import ifsp_pkg::*;

    logic       in_valid;
    logic       in_ready;
    ifsp_word_t in_data;
    logic       out_valid;
    logic       out_ready;
    ifsp_word_t out_data;

    modport store (
        input  in_valid,
        output in_ready,
        input  in_data,
        output out_valid,
        input  out_ready,
        output out_data
    );

    modport user (
        output in_valid,
        input  in_ready,
        output in_data,
        input  out_valid,
        output out_ready,
        input  out_data
    );
endinterface
`default_nettype wire

//--- hw/ifsp_buf.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two-entry buffer, head entry drives the output
// ****************************************************************
module ifsp_buf (
    input  wire logic   clk,
    input  wire logic   rst,
    ifsp_buf_if.store   bus
);
    import ifsp_pkg::*;

    logic       head_v_reg;
    logic       tail_v_reg;
    ifsp_word_t head_reg;
    ifsp_word_t tail_reg;
    logic       push;
    logic       pop;

    assign bus.in_ready  = ~tail_v_reg;
    assign bus.out_valid = head_v_reg;
    assign bus.out_data  = head_reg;
    assign push          = bus.in_valid & ~tail_v_reg;
    assign pop           = head_v_reg & bus.out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
            head_reg   <= WORD_RST;
            tail_reg   <= WORD_RST;
        end else if (pop && push) begin
            head_reg   <= bus.in_data;
            head_v_reg <= 1'b1;
        end else if (pop) begin
            head_reg   <= tail_reg;
            head_v_reg <= tail_v_reg;
            tail_v_reg <= 1'b0;
        end else if (push && !head_v_reg) begin
            head_reg   <= bus.in_data;
            head_v_reg <= 1'b1;
        end else if (push) begin
            tail_reg   <= bus.in_data;
            tail_v_reg <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- verif/ifsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checks
// ****************
module ifsp_chk (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 link_clk_in,
    input wire logic                 ser_data_out,
    input wire logic                 clear_to_send_n,
    input wire logic                 wake_flush_n,
    input wire logic                 power_enable_n,
    input wire logic                 remote_wakeup_en,
    input wire logic                 tx_valid,
    input wire logic                 tx_ready,
    input wire logic                 rx_valid,
    input wire logic                 rx_ready,
    input wire ifsp_pkg::ifsp_word_t rx_data,
    input wire logic                 flush_req,
    input wire logic                 resume_req
);
    import ifsp_pkg::*;
    AST_IDLE_HIGH: assert property (@(posedge link_clk_in)
        disable iff (rst) clear_to_send_n |-> ser_data_out)
        else $error("data line low while not sending");
    AST_START_LOW: assert property (@(posedge link_clk_in)
        disable iff (rst) $fell(clear_to_send_n) |-> !ser_data_out)
        else $error("no start bit with clear to send");
    AST_CTS_SPAN: assert property (@(posedge link_clk_in)
        disable iff (rst) $fell(clear_to_send_n)
        |=> !clear_to_send_n [*8] ##1 clear_to_send_n)
        else $error("clear to send span wrong");
    AST_TX_CTS: assert property (@(posedge clk)
        disable iff (rst) tx_valid && tx_ready
        |-> ##[2:20] !clear_to_send_n)
        else $error("taken word never offered");
    AST_TX_ONE: assert property (@(posedge clk)
        disable iff (rst) tx_valid && tx_ready |=> !tx_ready [*8])
        else $error("second word taken during frame");
    AST_FLUSH: assert property (@(posedge clk)
        disable iff (rst) $fell(wake_flush_n) && !power_enable_n
        |-> ##[2:6] flush_req ##1 !flush_req)
        else $error("strobe gave no flush pulse");
    AST_RESUME: assert property (@(posedge clk)
        disable iff (rst)
        $fell(wake_flush_n) && power_enable_n && remote_wakeup_en
        |-> ##[2:6] resume_req ##1 !resume_req)
        else $error("strobe gave no resume pulse");
    AST_RESUME_GATE: assert property (@(posedge clk)
        disable iff (rst) resume_req
        |-> power_enable_n && remote_wakeup_en && !flush_req)
        else $error("resume while not allowed");
    AST_RX_HOLD: assert property (@(posedge clk)
        disable iff (rst) rx_valid && !rx_ready
        |=> rx_valid && $stable(rx_data))
        else $error("received word lost in stall");
    cover property (@(posedge clk) flush_req);
    cover property (@(posedge clk) resume_req);
    cover property (@(posedge clk) rx_valid && rx_ready);
    cover property (@(posedge link_clk_in) $fell(clear_to_send_n));
endmodule
`default_nettype wire

//--- verif/ifsp_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// isolated peripheral
// ****************
module ifsp_peer (
    input  wire logic run,
    output logic      link_clk_in,
    output logic      ser_data_in,
    input  wire logic ser_data_out,
    input  wire logic clear_to_send_n
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    int         cnt;
    initial begin
        link_clk_in = 1'b0;
        ser_data_in = 1'b1;
        cnt = 0;
    end
    always #6 link_clk_in = run & ~link_clk_in;
    always @(negedge link_clk_in) begin
        if (cnt == 0) begin
            if (!clear_to_send_n && !ser_data_out)
                cnt = 1;
        end else if (cnt < 9) begin
            sh = {ser_data_out, sh[7:1]};
            cnt = cnt + 1;
        end else begin
            got_q.push_back(ser_data_out ? sh : ~sh);
            cnt = 0;
        end
    end
    task automatic send_frame(input logic [7:0] b, input logic trail);
        logic [9:0] f;
        f = {trail, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge link_clk_in);
            ser_data_in = f[i];
        end
        @(negedge link_clk_in);
        ser_data_in = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module tb;
    import ifsp_pkg::*;
    logic       clk, rst, run, link_clk_in, ser_data_in, ser_data_out;
    logic       clear_to_send_n, wake_flush_n, power_enable_n;
    logic       remote_wakeup_en, tx_valid, tx_ready, rx_valid, rx_ready;
    logic       flush_req, resume_req;
    ifsp_word_t tx_data, rx_data;
    int         errors, check_count;
    ifsp_top u_ifsp_top (.clk, .rst, .link_clk_in, .ser_data_in,
        .ser_data_out, .clear_to_send_n, .wake_flush_n, .power_enable_n,
        .remote_wakeup_en, .tx_valid, .tx_ready, .tx_data, .rx_valid,
        .rx_ready, .rx_data, .flush_req, .resume_req);
    ifsp_peer u_ifsp_peer (.run, .link_clk_in, .ser_data_in,
        .ser_data_out, .clear_to_send_n);
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_tx;
        logic [7:0] v[3];
        int         n;
        v = '{8'hA5, 8'h01, 8'h80};
        foreach (v[i]) begin
            n = 0;
            while (tx_ready !== 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            chk("tx ready", 8'h01, {7'h00, tx_ready});
            tx_valid = 1'b1;
            tx_data = v[i];
            @(negedge clk);
            tx_valid = 1'b0;
        end
        n = 0;
        while (u_ifsp_peer.got_q.size() < 3 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("tx count", 8'h03, 8'(u_ifsp_peer.got_q.size()));
        foreach (v[i])
            chk("tx byte", v[i], u_ifsp_peer.got_q[i]);
    endtask
    task automatic t_rx;
        logic [7:0] v[2];
        v = '{8'h3C, 8'hC3};
        rx_ready = 1'b0;
        foreach (v[i])
            u_ifsp_peer.send_frame(v[i], 1'b1);
        repeat (20) @(negedge clk);
        rx_ready = 1'b1;
        foreach (v[i]) begin
            chk("rx valid", 8'h01, {7'h00, rx_valid});
            chk("rx data", v[i], rx_data);
            @(negedge clk);
        end
        chk("rx empty", 8'h00, {7'h00, rx_valid});
        u_ifsp_peer.send_frame(8'h55, 1'b0);
        repeat (20) @(negedge clk);
        chk("rx bad frame", 8'h00, {7'h00, rx_valid});
    endtask
    task automatic t_strobe(input logic p, input logic w,
                            input logic [7:0] ef, input logic [7:0] er);
        int nf;
        int nr;
        nf = 0;
        nr = 0;
        power_enable_n = p;
        remote_wakeup_en = w;
        @(negedge clk);
        wake_flush_n = 1'b0;
        repeat (16) begin
            @(negedge clk);
            nf += int'(flush_req === 1'b1);
            nr += int'(resume_req === 1'b1);
        end
        wake_flush_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("flush pulses", ef, nf[7:0]);
        chk("resume pulses", er, nr[7:0]);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        run = 1'b1;
        wake_flush_n = 1'b1;
        power_enable_n = 1'b0;
        remote_wakeup_en = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("cts idle", 8'h01, {7'h00, clear_to_send_n});
        chk("line idle", 8'h01, {7'h00, ser_data_out});
        t_tx;
        t_rx;
        t_strobe(1'b0, 1'b0, 8'h01, 8'h00);
        t_strobe(1'b0, 1'b1, 8'h01, 8'h00);
        t_strobe(1'b1, 1'b1, 8'h00, 8'h01);
        t_strobe(1'b1, 1'b0, 8'h00, 8'h00);
        give_verdict;
    end
    initial begin
        #50000;
        errors++;
        give_verdict;
    end
endmodule
bind ifsp_top ifsp_chk u_ifsp_chk (.clk, .rst, .link_clk_in,
    .ser_data_out, .clear_to_send_n, .wake_flush_n, .power_enable_n,
    .remote_wakeup_en, .tx_valid, .tx_ready, .rx_valid, .rx_ready,
    .rx_data, .flush_req, .resume_req);
`default_nettype wire
